// ### shared/acc_cfg.svh
/*
 * constants for the dsp accumulator datapath: control bit positions, widths,
 * accumulator register indices and sign/clear fill values.
 * assumes it is included by bare name from any file that needs the numbers.
 */
// Overview of operation
// - integer operands are signed two's complement
// - fractional operands are 1.15, radix after sign
// - normal saturation keeps 1.31 in high:low
// - super saturation bit 4 enables 40-bit guard
// - saturation disabled also uses 40-bit guard
// - fractional radix stays at 31 fraction bits
// - non-multiply ops identical for both formats
// - control bit 0 selects multiply format
// - integer multiply gives unshifted 32-bit product
// - fractional multiply shifts product left one
// - accumulator is guard:high:low, 8+16+16 bits
// - load fills high, clears low, sign-extends guard
// - rounded store takes word from high register
// - normal saturation computes high:low, guard sign
// - super or disabled writes all 40 bits
// - six accumulator registers memory mapped read/write
// - guard register reads sign-extended to 16 bits
// - flags change only on dsp operations
// - double-word ops move high and low together
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

`define WORD_W          16
`define GUARD_W         8
`define ACC_W           40
`define PROD_W          32
`define CTL_FMT_BIT     0
`define CTL_SUPER_BIT   4
`define CTL_SAT_EN_BIT  7
`define REG_A_GUARD     3'h0
`define REG_A_HIGH      3'h1
`define REG_A_LOW       3'h2
`define REG_B_GUARD     3'h3
`define REG_B_HIGH      3'h4
`define REG_B_LOW       3'h5
`define ACC_RESET       40'h00_0000_0000
`define WORD_ZERO       16'h0000
`define GUARD_ONES      8'hff
`define GUARD_ZERO      8'h00

`endif

// ### shared/acc_pkg.sv
/*
 * types shared by the accumulator datapath: dsp opcodes and saturation views.
 * assumes acc_cfg.svh sits beside it on the include path.
 */
package acc_pkg;
    `include "acc_cfg.svh"

    // operation requested by instruction decode
    typedef enum logic [3:0] {
        op_none,
        load_acc_op,
        load_acc_double_op,
        store_acc_op,
        store_acc_rounded_op,
        store_acc_double_op,
        multiply_op,
        mul_accumulate_op,
        mul_subtract_op,
        add_acc_op
    } acc_op_t;

    // how the guard byte participates in a result
    typedef enum logic [1:0] {
        sat_normal,
        sat_super,
        sat_off
    } sat_view_t;
endpackage

// ### shared/acc_lane_if.sv
/*
 * lane interface between the accumulator top and its per-accumulator store.
 * assumes a single core clock domain shared by both ends.
 */
`timescale 1ns/1ps
`include "acc_cfg.svh"
interface acc_lane_if;
    logic                 wr_full;   // write 40-bit value
    logic [`ACC_W-1:0]    full_val;  // value for a full write
    logic                 wr_guard;  // memory write to guard byte
    logic                 wr_high;   // memory write to high word
    logic                 wr_low;    // memory write to low word
    logic [`WORD_W-1:0]   wdata;     // memory write data
    logic [`ACC_W-1:0]    acc;       // current accumulator value

    modport ctrl  (output wr_full, full_val, wr_guard, wr_high, wr_low, wdata, input acc);
    modport store (input wr_full, full_val, wr_guard, wr_high, wr_low, wdata, output acc);
endinterface

// ### rtl/acc_store.sv
/*
 * one 40-bit accumulator held as guard byte, high word and low word.
 * assumes the top arbitrates so only one write kind is active per cycle;
 * full writes win if several are raised.
 */
`timescale 1ns/1ps
`include "acc_cfg.svh"
module acc_store (
    input  wire logic    i_clk,
    input  wire logic    i_rst,
    acc_lane_if.store    lane
);
    import acc_pkg::*;

    logic [`GUARD_W-1:0] guard_byte, next_guard_byte;  // upper 8 bits
    logic [`WORD_W-1:0]  high_word,  next_high_word;   // middle 16 bits
    logic [`WORD_W-1:0]  low_word,   next_low_word;    // lower 16 bits

    // next value: a full write replaces everything, memory writes one part
    always_comb begin
        next_guard_byte = guard_byte;
        next_high_word  = high_word;
        next_low_word   = low_word;
        if (lane.wr_full) begin
            {next_guard_byte, next_high_word, next_low_word} = lane.full_val;
        end else begin
            // only the low byte is kept; reads rebuild the upper byte
            if (lane.wr_guard) next_guard_byte = lane.wdata[`GUARD_W-1:0];
            if (lane.wr_high)  next_high_word  = lane.wdata;
            if (lane.wr_low)   next_low_word   = lane.wdata;
        end
    end

    // register stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            {guard_byte, high_word, low_word} <= `ACC_RESET;
        end else begin
            guard_byte <= next_guard_byte;
            high_word  <= next_high_word;
            low_word   <= next_low_word;
        end
    end

    assign lane.acc = {guard_byte, high_word, low_word};
endmodule

// ### rtl/dsp_accumulator_datapath.sv
/*
 * accumulator datapath: two 40-bit accumulators, multiply format handling,
 * saturation views of the guard bits, load/store ops and memory-mapped access.
 * assumes instruction decode issues at most one op per cycle and that memory
 * accesses and ops do not target the same accumulator in the same cycle
 * (an op wins). the saturation/rounding arithmetic lives elsewhere; rounded
 * store here only selects the high word.
 */
`timescale 1ns/1ps
`include "acc_cfg.svh"
module dsp_accumulator_datapath (
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // core control register bits
    input  wire logic [`WORD_W-1:0]  i_core_control_reg,
    // instruction decode side
    input  wire logic                i_op_valid,
    input  wire acc_pkg::acc_op_t    i_op,
    input  wire logic                i_op_acc_sel,    // 0 = accumulator a
    input  wire logic [`WORD_W-1:0]  i_x_data,        // x bus operand / load word
    input  wire logic [`WORD_W-1:0]  i_y_data,        // y bus operand / low word
    output logic [`WORD_W-1:0]       o_store_high,
    output logic [`WORD_W-1:0]       o_store_low,
    output logic                     o_store_valid,
    // memory-mapped register access
    input  wire logic                i_mem_wr,
    input  wire logic                i_mem_rd,
    input  wire logic [2:0]          i_mem_addr,
    input  wire logic [`WORD_W-1:0]  i_mem_wdata,
    output logic [`WORD_W-1:0]       o_mem_rdata,
    // status flags
    output logic                     o_acc_a_ovf_flag,
    output logic                     o_acc_b_ovf_flag,
    output logic                     o_acc_a_clamp_flag,
    output logic                     o_acc_b_clamp_flag,
    // current accumulator values for the rounding/saturation logic
    output logic [`ACC_W-1:0]        o_accumulator_a,
    output logic [`ACC_W-1:0]        o_accumulator_b
);
    import acc_pkg::*;

    acc_lane_if lane_a ();   // accumulator a
    acc_lane_if lane_b ();   // accumulator b

    acc_store u_acc_a (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .lane  (lane_a)
    );

    acc_store u_acc_b (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .lane  (lane_b)
    );

    sat_view_t             sat_view;      // active guard-bit view
    logic                  int_mode;      // multiply format, 1 = integer
    logic [`ACC_W-1:0]     acc_sel;       // accumulator targeted by the op
    logic [`PROD_W-1:0]    product;       // aligned multiply result
    logic [`ACC_W-1:0]     prod_ext;      // product widened to 40 bits
    logic [`ACC_W-1:0]     raw_result;    // full 40-bit arithmetic result
    logic [`ACC_W-1:0]     result;        // result seen through sat view
    logic                  result_wr;     // op writes an accumulator
    logic                  is_dsp;        // op is a dsp arithmetic op
    logic                  ovf;           // result overflows 32 bits
    logic                  ovf_full;      // result overflows 40 bits

    logic [`WORD_W-1:0]    store_high, next_store_high;
    logic [`WORD_W-1:0]    store_low,  next_store_low;
    logic                  store_valid, next_store_valid;
    logic [`WORD_W-1:0]    mem_rdata, next_mem_rdata;
    logic                  a_ovf, next_a_ovf;
    logic                  b_ovf, next_b_ovf;
    logic                  a_clamp, next_a_clamp;
    logic                  b_clamp, next_b_clamp;

    // control bit decode; saturation enable is a separate control bit
    always_comb begin
        int_mode = i_core_control_reg[`CTL_FMT_BIT];
        if (i_core_control_reg[`CTL_SUPER_BIT]) begin
            sat_view = sat_super;
        end else if (!i_core_control_reg[`CTL_SAT_EN_BIT]) begin
            sat_view = sat_off;
        end else begin
            sat_view = sat_normal;
        end
    end

    // multiply: signed operands, fractional mode shifts the 2.30 product
    always_comb begin
        logic signed [`PROD_W-1:0] raw_prod;
        raw_prod = $signed(i_x_data) * $signed(i_y_data);
        if (int_mode) begin
            product = raw_prod;
        end else begin
            // guard bits take the true product sign so -1.0 * -1.0 reads +1.0
            product = {raw_prod[`PROD_W-2:0], 1'b0};
        end
        prod_ext = {{`GUARD_W{raw_prod[`PROD_W-1]}}, product};
    end

    // arithmetic: same adder for both formats, only multiply differs
    always_comb begin
        acc_sel    = i_op_acc_sel ? lane_b.acc : lane_a.acc;
        raw_result = acc_sel;
        result_wr  = 1'b0;
        is_dsp     = 1'b0;
        if (i_op_valid) begin
            case (i_op)
                load_acc_op: begin
                    // high gets the word, low zero, guard the sign
                    raw_result = {{`GUARD_W{i_x_data[`WORD_W-1]}}, i_x_data, `WORD_ZERO};
                    result_wr  = 1'b1;
                end
                load_acc_double_op: begin
                    raw_result = {{`GUARD_W{i_x_data[`WORD_W-1]}}, i_x_data, i_y_data};
                    result_wr  = 1'b1;
                end
                multiply_op: begin
                    raw_result = prod_ext;
                    result_wr  = 1'b1;
                    is_dsp     = 1'b1;
                end
                mul_accumulate_op: begin
                    raw_result = acc_sel + prod_ext;
                    result_wr  = 1'b1;
                    is_dsp     = 1'b1;
                end
                mul_subtract_op: begin
                    raw_result = acc_sel - prod_ext;
                    result_wr  = 1'b1;
                    is_dsp     = 1'b1;
                end
                add_acc_op: begin
                    // a+b into the target; identical bits for int or frac data
                    raw_result = lane_a.acc + lane_b.acc;
                    result_wr  = 1'b1;
                    is_dsp     = 1'b1;
                end
                default: begin
                    raw_result = acc_sel;
                end
            endcase
        end
    end

    // overflow detection: bits 39..31 disagree means beyond 1.31 range
    always_comb begin
        ovf      = (raw_result[`ACC_W-1:`PROD_W-1] != {(`GUARD_W+1){1'b0}})
                && (raw_result[`ACC_W-1:`PROD_W-1] != {(`GUARD_W+1){1'b1}});
        // 40-bit carry out is not visible here; approximate by guard sign flip
        ovf_full = (i_op == mul_accumulate_op || i_op == mul_subtract_op)
                && (acc_sel[`ACC_W-1] == (i_op == mul_accumulate_op ?
                    prod_ext[`ACC_W-1] : ~prod_ext[`ACC_W-1]))
                && (raw_result[`ACC_W-1] != acc_sel[`ACC_W-1]);
        if (is_dsp && sat_view == sat_normal) begin
            // only high:low is kept, guard just follows the sign
            result = {{`GUARD_W{raw_result[`PROD_W-1]}}, raw_result[`PROD_W-1:0]};
        end else begin
            result = raw_result;
        end
    end

    // lane drive: ops write whole value, memory writes one register
    always_comb begin
        lane_a.wr_full  = result_wr && !i_op_acc_sel;
        lane_b.wr_full  = result_wr && i_op_acc_sel;
        lane_a.full_val = result;
        lane_b.full_val = result;
        lane_a.wdata    = i_mem_wdata;
        lane_b.wdata    = i_mem_wdata;
        lane_a.wr_guard = i_mem_wr && (i_mem_addr == `REG_A_GUARD);
        lane_a.wr_high  = i_mem_wr && (i_mem_addr == `REG_A_HIGH);
        lane_a.wr_low   = i_mem_wr && (i_mem_addr == `REG_A_LOW);
        lane_b.wr_guard = i_mem_wr && (i_mem_addr == `REG_B_GUARD);
        lane_b.wr_high  = i_mem_wr && (i_mem_addr == `REG_B_HIGH);
        lane_b.wr_low   = i_mem_wr && (i_mem_addr == `REG_B_LOW);
    end

    // store path and register read data, both one cycle later
    always_comb begin
        next_store_high  = store_high;
        next_store_low   = store_low;
        next_store_valid = 1'b0;
        if (i_op_valid) begin
            if (i_op == store_acc_op || i_op == store_acc_rounded_op) begin
                next_store_high  = acc_sel[`PROD_W-1:`WORD_W];
                next_store_valid = 1'b1;
            end else if (i_op == store_acc_double_op) begin
                next_store_high  = acc_sel[`PROD_W-1:`WORD_W];
                next_store_low   = acc_sel[`WORD_W-1:0];
                next_store_valid = 1'b1;
            end
        end
        next_mem_rdata = mem_rdata;
        if (i_mem_rd) begin
            // guard reads come back sign-extended for byte or word access
            if (i_mem_addr == `REG_A_GUARD) begin
                next_mem_rdata = {{`GUARD_W{lane_a.acc[`ACC_W-1]}},
                                  lane_a.acc[`ACC_W-1:`PROD_W]};
            end else if (i_mem_addr == `REG_A_HIGH) begin
                next_mem_rdata = lane_a.acc[`PROD_W-1:`WORD_W];
            end else if (i_mem_addr == `REG_A_LOW) begin
                next_mem_rdata = lane_a.acc[`WORD_W-1:0];
            end else if (i_mem_addr == `REG_B_GUARD) begin
                next_mem_rdata = {{`GUARD_W{lane_b.acc[`ACC_W-1]}},
                                  lane_b.acc[`ACC_W-1:`PROD_W]};
            end else if (i_mem_addr == `REG_B_HIGH) begin
                next_mem_rdata = lane_b.acc[`PROD_W-1:`WORD_W];
            end else if (i_mem_addr == `REG_B_LOW) begin
                next_mem_rdata = lane_b.acc[`WORD_W-1:0];
            end else begin
                next_mem_rdata = `WORD_ZERO;   // unmapped index reads zero
            end
        end
    end

    // flags: updated only by dsp ops, never by memory writes or loads
    always_comb begin
        next_a_ovf   = a_ovf;
        next_b_ovf   = b_ovf;
        next_a_clamp = a_clamp;
        next_b_clamp = b_clamp;
        if (is_dsp) begin
            if (!i_op_acc_sel) begin
                next_a_ovf   = ovf;
                next_a_clamp = a_clamp | ovf_full;
            end else begin
                next_b_ovf   = ovf;
                next_b_clamp = b_clamp | ovf_full;
            end
        end
    end

    // register stage for outputs and flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            store_high  <= `WORD_ZERO;
            store_low   <= `WORD_ZERO;
            store_valid <= 1'b0;
            mem_rdata   <= `WORD_ZERO;
            a_ovf       <= 1'b0;
            b_ovf       <= 1'b0;
            a_clamp     <= 1'b0;
            b_clamp     <= 1'b0;
        end else begin
            store_high  <= next_store_high;
            store_low   <= next_store_low;
            store_valid <= next_store_valid;
            mem_rdata   <= next_mem_rdata;
            a_ovf       <= next_a_ovf;
            b_ovf       <= next_b_ovf;
            a_clamp     <= next_a_clamp;
            b_clamp     <= next_b_clamp;
        end
    end

    assign o_store_high       = store_high;
    assign o_store_low        = store_low;
    assign o_store_valid      = store_valid;
    assign o_mem_rdata        = mem_rdata;
    assign o_acc_a_ovf_flag   = a_ovf;
    assign o_acc_b_ovf_flag   = b_ovf;
    assign o_acc_a_clamp_flag = a_clamp;
    assign o_acc_b_clamp_flag = b_clamp;
    assign o_accumulator_a    = lane_a.acc;
    assign o_accumulator_b    = lane_b.acc;
endmodule

// ### tb/decode_model.sv
/*
 * stand-in for instruction decode and the x/y operand buses.
 * assumes the bench calls issue() from its main sequence, one op per call.
 */
`timescale 1ns/1ps
module decode_model
    import acc_pkg::*;
(
    input  wire logic        i_clk,
    output logic             o_op_valid,
    output acc_pkg::acc_op_t o_op,
    output logic             o_op_acc_sel,
    output logic [15:0]      o_x_data,
    output logic [15:0]      o_y_data
);
    // idle until the first issue
    initial begin
        o_op_valid = 1'b0;
        o_op = op_none;
        o_op_acc_sel = 1'b0;
        o_x_data = 16'h0000;
        o_y_data = 16'h0000;
    end

    // loads and stores go only through the dedicated ops
    task issue(input acc_op_t op, input logic sel, input logic [15:0] x, input logic [15:0] y);
        @(posedge i_clk);
        o_op_valid <= 1'b1;
        o_op <= op;
        o_op_acc_sel <= sel;
        o_x_data <= x;
        o_y_data <= y;
        @(posedge i_clk);
        o_op_valid <= 1'b0;
        // released buses do not keep the old operand
        o_x_data <= ~x;
        o_y_data <= ~y;
    endtask
endmodule

// ### tb/dsp_accumulator_datapath_assertions.sv
/*
 * port-level properties of the accumulator datapath.
 * assumes one core clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module dsp_accumulator_datapath_checker
    import acc_pkg::*;
(
    input wire logic             i_clk,
    input wire logic             i_rst,
    input wire logic [15:0]      i_core_control_reg,
    input wire logic             i_op_valid,
    input wire acc_pkg::acc_op_t i_op,
    input wire logic             i_op_acc_sel,
    input wire logic [15:0]      i_x_data,
    input wire logic [15:0]      i_y_data,
    input wire logic [15:0]      o_store_high,
    input wire logic [15:0]      o_store_low,
    input wire logic             o_store_valid,
    input wire logic             i_mem_wr,
    input wire logic             i_mem_rd,
    input wire logic [2:0]       i_mem_addr,
    input wire logic [15:0]      i_mem_wdata,
    input wire logic [15:0]      o_mem_rdata,
    input wire logic             o_acc_a_ovf_flag,
    input wire logic             o_acc_b_ovf_flag,
    input wire logic             o_acc_a_clamp_flag,
    input wire logic             o_acc_b_clamp_flag,
    input wire logic [39:0]      o_accumulator_a,
    input wire logic [39:0]      o_accumulator_b
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic               sel_q;  // target of the previous cycle
    logic [15:0]        x_q;    // operands one cycle back
    logic [15:0]        y_q;
    logic [15:0]        w_q;    // write data one cycle back
    logic [39:0]        a_q;    // accumulators one cycle back
    logic [39:0]        b_q;
    logic [39:0]        tgt;    // accumulator written by the previous op
    logic [39:0]        tgt_q;  // that accumulator before the op
    logic signed [31:0] prod;   // raw signed product of the held operands
    logic               op_go;  // op with no competing memory write

    // a one-cycle history instead of $past keeps slicing legal
    always_ff @(posedge i_clk) begin
        sel_q <= i_op_acc_sel;
        x_q <= i_x_data;
        y_q <= i_y_data;
        w_q <= i_mem_wdata;
        a_q <= o_accumulator_a;
        b_q <= o_accumulator_b;
    end
    assign tgt = sel_q ? o_accumulator_b : o_accumulator_a;
    assign tgt_q = sel_q ? b_q : a_q;
    assign prod = $signed(x_q) * $signed(y_q);
    assign op_go = i_op_valid && !i_mem_wr;

    load_sign_fill_a: assert property (op_go && i_op == load_acc_op |=>
        tgt == {{8{x_q[15]}}, x_q, 16'h0000}) else $error("load fill wrong");
    round_store_word_a: assert property (op_go && i_op == store_acc_rounded_op |=>
        o_store_valid && o_store_high == tgt_q[31:16]) else $error("rounded store wrong");
    double_store_pair_a: assert property (op_go && i_op == store_acc_double_op |=>
        {o_store_high, o_store_low} == tgt_q[31:0]) else $error("double store wrong");
    guard_read_sext_a: assert property (i_mem_rd && i_mem_addr == 3'h0 |=>
        o_mem_rdata == {{8{a_q[39]}}, a_q[39:32]}) else $error("guard read wrong");
    high_read_word_a: assert property (i_mem_rd && i_mem_addr == 3'h4 |=>
        o_mem_rdata == b_q[31:16]) else $error("high read wrong");
    guard_write_byte_a: assert property (i_mem_wr && i_mem_addr == 3'h3 && !i_op_valid |=>
        o_accumulator_b == {w_q[7:0], b_q[31:0]}) else $error("guard write wrong");
    flags_only_dsp_a: assert property (!$past(i_op_valid) |-> $stable({o_acc_a_ovf_flag,
        o_acc_b_ovf_flag, o_acc_a_clamp_flag, o_acc_b_clamp_flag})) else $error("flag moved");
    normal_guard_sign_a: assert property (op_go && i_op == multiply_op
        && i_core_control_reg[7] && !i_core_control_reg[4] |=> tgt[39:32] == {8{tgt[31]}})
        else $error("normal view guard wrong");
    int_product_a: assert property (op_go && i_op == multiply_op && i_core_control_reg[0]
        |=> tgt[31:0] == prod) else $error("integer product wrong");
    frac_product_shift_a: assert property (op_go && i_op == multiply_op
        && !i_core_control_reg[0] |=> tgt[31:0] == {prod[30:0], 1'b0})
        else $error("fraction product wrong");

    cover property (op_go && i_op == multiply_op && i_core_control_reg[4]);
    cover property (i_mem_rd && i_mem_addr == 3'h0);
    cover property (op_go && i_op == store_acc_double_op);
endmodule

bind dsp_accumulator_datapath dsp_accumulator_datapath_checker u_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_core_control_reg(i_core_control_reg),
    .i_op_valid(i_op_valid), .i_op(i_op), .i_op_acc_sel(i_op_acc_sel),
    .i_x_data(i_x_data), .i_y_data(i_y_data), .o_store_high(o_store_high),
    .o_store_low(o_store_low), .o_store_valid(o_store_valid), .i_mem_wr(i_mem_wr),
    .i_mem_rd(i_mem_rd), .i_mem_addr(i_mem_addr), .i_mem_wdata(i_mem_wdata),
    .o_mem_rdata(o_mem_rdata), .o_acc_a_ovf_flag(o_acc_a_ovf_flag),
    .o_acc_b_ovf_flag(o_acc_b_ovf_flag), .o_acc_a_clamp_flag(o_acc_a_clamp_flag),
    .o_acc_b_clamp_flag(o_acc_b_clamp_flag), .o_accumulator_a(o_accumulator_a),
    .o_accumulator_b(o_accumulator_b));

// ### tb/test_dsp_accumulator_datapath.sv
/*
 * self-checking bench for the accumulator datapath.
 * assumes decode_model drives the op side and the checker is bound.
 */
`timescale 1ns/1ps
module test_dsp_accumulator_datapath;
    import acc_pkg::*;
    logic clk, rst, mem_wr, mem_rd, op_valid, sel, st_valid;
    logic [2:0] mem_addr;
    logic [15:0] ctl, mem_wdata, x, y, st_high, st_low, rdata;
    logic [3:0] flags;
    logic [39:0] acc_a, acc_b;
    acc_op_t op_code;
    int miscompares, total_checks, cycles;
    // view, format and the product of 0x8000 squared under each
    logic [15:0] ctl_tab [5] = '{16'h0080, 16'h0081, 16'h0090, 16'h0091, 16'h0000};
    logic [39:0] exp_tab [5] = '{40'hff_8000_0000, 40'h00_4000_0000, 40'h00_8000_0000,
                                 40'h00_4000_0000, 40'h00_8000_0000};

    decode_model u_dec (.i_clk(clk), .o_op_valid(op_valid), .o_op(op_code),
        .o_op_acc_sel(sel), .o_x_data(x), .o_y_data(y));
    dsp_accumulator_datapath DUT (.i_clk(clk), .i_rst(rst), .i_core_control_reg(ctl),
        .i_op_valid(op_valid), .i_op(op_code), .i_op_acc_sel(sel), .i_x_data(x),
        .i_y_data(y), .o_store_high(st_high), .o_store_low(st_low), .o_store_valid(st_valid),
        .i_mem_wr(mem_wr), .i_mem_rd(mem_rd), .i_mem_addr(mem_addr), .i_mem_wdata(mem_wdata),
        .o_mem_rdata(rdata), .o_acc_a_ovf_flag(flags[0]), .o_acc_b_ovf_flag(flags[1]),
        .o_acc_a_clamp_flag(flags[2]), .o_acc_b_clamp_flag(flags[3]),
        .o_accumulator_a(acc_a), .o_accumulator_b(acc_b));

    // 20 ns core clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // a hang is cut short well past the expected run of under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            test_done();
        end
    end

    task check(input string what, input logic [39:0] exp, input logic [39:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one op, judged after the edge that takes it
    task op(input acc_op_t o, input logic s, input logic [15:0] xv, input logic [15:0] yv);
        u_dec.issue(o, s, xv, yv);
        #1;
    endtask

    // one register access; read data is settled on return
    task mem(input logic wr, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        mem_wr <= wr;
        mem_rd <= !wr;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk);
        mem_wr <= 1'b0;
        mem_rd <= 1'b0;
        mem_wdata <= ~d;
        #1;
    endtask

    task t_load;
        op(load_acc_op, 1'b0, 16'h8000, 16'h0000);
        check("acc a", 40'hff_8000_0000, acc_a);
        op(load_acc_op, 1'b1, 16'h7fff, 16'h0000);
        check("acc b", 40'h00_7fff_0000, acc_b);
        mem(1'b0, 3'h0, 16'h0000);
        check("guard a read", 40'hffff, rdata);
        mem(1'b0, 3'h1, 16'h0000);
        check("high a read", 40'h8000, rdata);
        mem(1'b0, 3'h6, 16'h0000);
        check("unmapped read", 40'h0000, rdata);
    endtask

    task t_mem;
        mem(1'b1, 3'h2, 16'h1234);
        mem(1'b1, 3'h1, 16'h7fff);
        mem(1'b1, 3'h0, 16'h1280);
        check("acc a", 40'h80_7fff_1234, acc_a);
        mem(1'b0, 3'h0, 16'h0000);
        check("guard a read", 40'hff80, rdata);
        mem(1'b1, 3'h7, 16'hffff);
        check("acc b", 40'h00_7fff_0000, acc_b);
        check("flags", 40'h0, flags);
        mem(1'b1, 3'h3, 16'h12ff);
        mem(1'b0, 3'h4, 16'h0000);
        check("high b read", 40'h7fff, rdata);
        check("acc b", 40'hff_7fff_0000, acc_b);
    endtask

    task t_store;
        op(store_acc_rounded_op, 1'b0, 16'h0000, 16'h0000);
        check("rounded store", 40'h1_7fff, {st_valid, st_high});
        op(load_acc_double_op, 1'b1, 16'h1234, 16'h5678);
        op(store_acc_double_op, 1'b1, 16'h0000, 16'h0000);
        check("double store", 40'h1234_5678, {st_high, st_low});
        op(store_acc_op, 1'b1, 16'h0000, 16'h0000);
        check("plain store", 40'h1234, st_high);
    endtask

    task t_mul;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            ctl <= ctl_tab[i];
            op(multiply_op, 1'b0, 16'h8000, 16'h8000);
            // covers format select, shift and all three views
            check("product", exp_tab[i], acc_a);
        end
        @(posedge clk);
        ctl <= 16'h0090;
        op(mul_accumulate_op, 1'b0, 16'h8000, 16'h8000);
        check("accumulate", 40'h01_0000_0000, acc_a);
        op(mul_subtract_op, 1'b0, 16'h8000, 16'h8000);
        check("subtract", 40'h00_8000_0000, acc_a);
        check("ovf flag", 40'h1, flags);
    endtask

    task t_add;
        @(posedge clk);
        ctl <= 16'h0091;
        op(load_acc_op, 1'b0, 16'h4000, 16'h0000);
        op(load_acc_op, 1'b1, 16'h2000, 16'h0000);
        op(add_acc_op, 1'b1, 16'h0000, 16'h0000);
        check("int sum", 40'h00_6000_0000, acc_b);
        @(posedge clk);
        ctl <= 16'h0090;
        op(add_acc_op, 1'b1, 16'h0000, 16'h0000);
        check("frac sum", 40'h00_a000_0000, acc_b);
        @(posedge clk);
        ctl <= 16'h0080;
        op(add_acc_op, 1'b1, 16'h0000, 16'h0000);
        check("normal sum", 40'hff_e000_0000, acc_b);
    endtask

    initial begin
        rst = 1'b1;
        ctl = 16'h0080;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_addr = 3'h0;
        mem_wdata = 16'h0000;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("acc a after reset", 40'h0, acc_a);
        check("flags after reset", 40'h0, flags);
        t_load();
        t_mem();
        t_store();
        t_mul();
        t_add();
        test_done();
    end
endmodule
